// ===== logic/file_alu_pkg.sv
// Constants for the file-register execute datapath
package file_alu_pkg;
  localparam int          WORD_W        = 14;
  localparam int          DATA_W        = 8;
  localparam int          ADDR_W        = 7;
  localparam logic [1:0]  CLASS_BYTE    = 2'h0;
  localparam logic [1:0]  CLASS_BIT     = 2'h1;
  localparam logic [3:0]  OP_ADD        = 4'h7;
  localparam logic [3:0]  OP_AND        = 4'h5;
  localparam logic [1:0]  OP_BIT_CLEAR  = 2'h0;
  localparam logic [1:0]  OP_BIT_TEST   = 2'h2;
  localparam int          CLASS_MSB     = 13;
  localparam int          OP_MSB        = 11;
  localparam int          DEST_BIT      = 7;
  localparam int          BITSEL_MSB    = 9;
  localparam int          BITSEL_LSB    = 7;
  localparam logic [6:0]  TIMER0_ADDR   = 7'h01;
  localparam logic [7:0]  W_RESET       = 8'h00;
  localparam logic [13:0] NO_OPERATION  = 14'h0000;
  localparam logic [2:0]  FLAGS_RESET   = 3'h0;
  localparam int          FLAG_C        = 0;
  localparam int          FLAG_DC       = 1;
  localparam int          FLAG_Z        = 2;
  typedef enum logic [2:0] {
    OPC_NONE  = 3'b000,
    OPC_ADD   = 3'b001,
    OPC_AND   = 3'b010,
    OPC_CLEAR = 3'b011,
    OPC_TEST  = 3'b100
  } op_kind_t;
endpackage : file_alu_pkg

// ===== logic/alu_core_calc.sv
// Combinational adder, AND and bit operations with flag results
`timescale 1ns/100ps
module alu_core_calc
  import file_alu_pkg::*;
(
  input  wire op_kind_t    kind,
  input  wire logic [7:0]  work_val,
  input  wire logic [7:0]  file_val,
  input  wire logic [2:0]  bit_sel,
  output      logic [7:0]  result,
  output      logic        carry,
  output      logic        digit_carry,
  output      logic        zero,
  output      logic        bit_value
);
  logic [8:0] sum;
  logic [4:0] low_sum;

  always_comb begin
    sum         = {1'b0, work_val} + {1'b0, file_val};
    low_sum     = {1'b0, work_val[3:0]} + {1'b0, file_val[3:0]};
    result      = file_val;
    carry       = sum[8];
    digit_carry = low_sum[4];
    bit_value   = file_val[bit_sel];
    unique case (kind)
      OPC_ADD:   result = sum[7:0];
      OPC_AND:   result = work_val & file_val;
      OPC_CLEAR: result = file_val & ~(8'h01 << bit_sel);
      OPC_NONE,
      OPC_TEST:  result = file_val;
    endcase
    // RULE9 zero from result
    zero = (result == 8'h00);
  end
endmodule // alu_core_calc

// ===== logic/file_alu_bit_ops_exec.sv
// Execute stage for add, AND, bit-clear and bit-test-skip instructions
// Overview of operation
// RULE1 - Add sums W and the file register and updates carry, digit carry, zero.
// RULE2 - AND forms W AND file, changing only the zero flag.
// RULE3 - Add and AND results go to W when destination is 0, else to the file.
// RULE4 - Bit clear zeroes one selected bit of the file register, no flag change.
// RULE5 - Bit test skips the next instruction when the bit is 0, no flag change.
// RULE6 - On skip the prefetched instruction is replaced by a no-operation.
// RULE7 - Port registers modified as a function of themselves read pin levels.
// RULE8 - Writing the timer0 count clears the prescaler when assigned to timer0.
// RULE9 - Zero flag is set when the 8-bit add or AND result is all zeros.
//
// Chosen here: the plain strobed port and the register addresses.
`timescale 1ns/100ps
module file_alu_bit_ops_exec
  import file_alu_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  input  wire logic        instr_valid,
  input  wire logic [13:0] instr_word,
  input  wire logic [13:0] prefetch_word,
  input  wire logic [7:0]  file_rd_data,
  input  wire logic [7:0]  port_pin_data,
  input  wire logic        file_is_port,
  input  wire logic        prescaler_to_timer0,
  output      logic [6:0]  file_addr,
  output      logic        file_wr_en,
  output      logic [7:0]  file_wr_data,
  output      logic [7:0]  work_q,
  output      logic        carry_q,
  output      logic        digit_carry_flag_q,
  output      logic        zero_q,
  output      logic        skip_q,
  output      logic [13:0] exec_next_word,
  output      logic        prescaler_clear
);
  op_kind_t   kind;
  logic [7:0] operand;
  logic [7:0] result;
  logic       sum_c;
  logic       sum_dc;
  logic       res_z;
  logic       bit_val;
  logic       dest_file;
  logic       skip_d;
  logic       writes_file;
  logic [2:0] bit_sel;
  logic       writes_work;
  logic       updates_z;
  logic       timer0_hit;

  // A word executes in the cycle in which instr_valid is high; W, the
  // flags, the file write and the skip flag appear one clock later.
  // The file read is combinational, so the register file must settle
  // its output within the executing cycle, pins included.

  // Encodings outside the four kinds decode to OPC_NONE and change nothing
  function automatic op_kind_t decode(input logic [13:0] w);
    op_kind_t k;
    k = OPC_NONE;
    if (w[CLASS_MSB -: 2] == CLASS_BYTE) begin
      if (w[OP_MSB -: 4] == OP_ADD)
        k = OPC_ADD;
      else if (w[OP_MSB -: 4] == OP_AND)
        k = OPC_AND;
    end else if (w[CLASS_MSB -: 2] == CLASS_BIT) begin
      if (w[OP_MSB -: 2] == OP_BIT_CLEAR)
        k = OPC_CLEAR;
      else if (w[OP_MSB -: 2] == OP_BIT_TEST)
        k = OPC_TEST;
    end
    return k;
  endfunction

  // Add and AND share the W destination and the zero flag path
  function automatic logic is_byte_op(input op_kind_t k);
    return (k == OPC_ADD) || (k == OPC_AND);
  endfunction

  // Bit test only reads; every other kind may write back what it read
  function automatic logic reads_pins(input op_kind_t k);
    return (k != OPC_TEST);
  endfunction

  // The prescaler clear follows a write-back to the timer0 count while the prescaler is assigned to timer0
  function automatic logic is_timer0(input logic [6:0] a);
    return (a == TIMER0_ADDR);
  endfunction

  // Skipped slot executes as nothing, whatever its encoding
  always_comb begin
    kind = OPC_NONE;
    if (instr_valid && !skip_q)
      kind = decode(instr_word);
  end

  assign file_addr = instr_word[ADDR_W-1:0];
  assign dest_file = instr_word[DEST_BIT];
  assign bit_sel   = instr_word[BITSEL_MSB:BITSEL_LSB];

  // Qualifiers shared by the write-back, flag and prescaler paths
  assign writes_work = is_byte_op(kind) && !dest_file;
  assign updates_z   = is_byte_op(kind);
  assign timer0_hit  = writes_file && is_timer0(file_addr);

  // RULE7 pin levels as source
  // Reading the latch would write back a level that an outside driver
  // has overridden; the test has no write-back and keeps the file value
  always_comb begin
    operand = file_rd_data;
    if (file_is_port && reads_pins(kind))
      operand = port_pin_data;
  end

  // The calculator is purely combinational; its results are captured
  // by the registers below at the end of the executing cycle
  alu_core_calc alu_core_calc_i (
    .kind        (kind),
    .work_val    (work_q),
    .file_val    (operand),
    .bit_sel     (bit_sel),
    .result      (result),
    .carry       (sum_c),
    .digit_carry (sum_dc),
    .zero        (res_z),
    .bit_value   (bit_val)
  );

  // RULE3 destination select
  always_comb begin
    writes_file = 1'b0;
    unique case (kind)
      OPC_ADD,
      OPC_AND:   writes_file = dest_file;
      // RULE4 clear writes back
      OPC_CLEAR: writes_file = 1'b1;
      OPC_NONE,
      OPC_TEST:  writes_file = 1'b0;
    endcase
  end

  // Write data is registered; the file commits at the next edge
  // RULE3 RULE4 write strobe
  always_ff @(posedge clk_sys) begin
    if (!rstn)
      file_wr_en <= 1'b0;
    else
      file_wr_en <= writes_file;
  end

  // Data follow result every cycle; only the strobe qualifies them
  always_ff @(posedge clk_sys) begin
    if (!rstn)
      file_wr_data <= W_RESET;
    else
      file_wr_data <= result;
  end

  // RULE8 timer0 prescaler clear
  always_ff @(posedge clk_sys) begin
    if (!rstn)
      prescaler_clear <= 1'b0;
    else
      prescaler_clear <= timer0_hit && prescaler_to_timer0;
  end

  // RULE3 result to W
  always_ff @(posedge clk_sys) begin
    if (!rstn)
      work_q <= W_RESET;
    else if (writes_work)
      work_q <= result;
  end

  // RULE1 add carry
  always_ff @(posedge clk_sys) begin
    if (!rstn)
      carry_q <= FLAGS_RESET[FLAG_C];
    else if (kind == OPC_ADD)
      carry_q <= sum_c;
  end

  // RULE1 add digit carry
  // Only add touches it; AND and the bit kinds leave it as it was
  always_ff @(posedge clk_sys) begin
    if (!rstn)
      digit_carry_flag_q <= FLAGS_RESET[FLAG_DC];
    else if (kind == OPC_ADD)
      digit_carry_flag_q <= sum_dc;
  end

  // RULE2 zero for add and AND
  always_ff @(posedge clk_sys) begin
    if (!rstn)
      zero_q <= FLAGS_RESET[FLAG_Z];
    else if (updates_z)
      zero_q <= res_z;
  end

  // RULE5 skip on clear bit
  always_comb begin
    skip_d = 1'b0;
    if (kind == OPC_TEST)
      skip_d = !bit_val;
  end

  // Cleared by the next valid slot only; an idle gap keeps it, so a
  // stall between test and fetch still squashes the right word
  always_ff @(posedge clk_sys) begin
    if (!rstn)
      skip_q <= 1'b0;
    else if (instr_valid)
      skip_q <= skip_d;
  end

  // RULE6 discard prefetch
  // The no-operation word is all zeros, so reset and a skip look alike
  always_ff @(posedge clk_sys) begin
    if (!rstn)
      exec_next_word <= NO_OPERATION;
    else if (instr_valid)
      exec_next_word <= skip_d ? NO_OPERATION : prefetch_word;
  end
endmodule // file_alu_bit_ops_exec

// ===== tb/file_alu_bit_ops_exec_chk.sv
// Port checks for the file-register execute datapath
`timescale 1ns/100ps
module file_alu_bit_ops_exec_chk
  import file_alu_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        rstn,
  input wire logic        instr_valid,
  input wire logic [13:0] instr_word,
  input wire logic [7:0]  file_rd_data,
  input wire logic [7:0]  port_pin_data,
  input wire logic        file_is_port,
  input wire logic        prescaler_to_timer0,
  input wire logic        file_wr_en,
  input wire logic [7:0]  file_wr_data,
  input wire logic [7:0]  work_q,
  input wire logic        carry_q,
  input wire logic        digit_carry_flag_q,
  input wire logic        zero_q,
  input wire logic        skip_q,
  input wire logic [13:0] exec_next_word,
  input wire logic        prescaler_clear
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  logic [8:0] sum_q;
  logic [7:0] clr_q;
  logic       dc_q;
  logic [7:0] and_q;
  wire  [7:0] src = file_is_port ? port_pin_data : file_rd_data;
  wire        ex  = instr_valid && !skip_q;
  wire        add = ex && instr_word[13:8] == 6'h07;
  wire        anw = ex && instr_word[13:8] == 6'h05;
  wire        clr = ex && instr_word[13:10] == 4'h4;
  wire        wf  = clr || (add || anw) && instr_word[7];
  always_ff @(posedge clk_sys) begin
    sum_q <= {1'h0, work_q} + {1'h0, src};
    dc_q  <= {1'h0, work_q[3:0]} + {1'h0, src[3:0]} > 5'h0F;
    clr_q <= src & ~(8'h01 << instr_word[9:7]);
    and_q <= work_q & src;
  end
  chk_and_work:
    assert property (anw && !instr_word[7] |=> work_q == and_q
      && zero_q == (and_q == 8'h00)) else $error("and to W");
  chk_add_flags:
    assert property (add |=> carry_q == sum_q[8] && digit_carry_flag_q == dc_q
      && zero_q == (sum_q[7:0] == 8'h00)) else $error("add flags");
  chk_add_work:
    assert property (add && !instr_word[7] |=> work_q == sum_q[7:0])
      else $error("add to W");
  chk_and_flags:
    assert property (anw |=> $stable(carry_q) && $stable(digit_carry_flag_q))
      else $error("and flags");
  chk_file_dest:
    assert property ((add || anw) && instr_word[7] |=> file_wr_en
      && $stable(work_q)) else $error("file dest");
  chk_clear_bit:
    assert property (clr |=> file_wr_en && file_wr_data == clr_q
      && $stable(carry_q)) else $error("bit clear");
  chk_skip_nop:
    assert property (ex && instr_word[13:10] == 4'h6
      && !file_rd_data[instr_word[9:7]] |=> skip_q
      && exec_next_word == NO_OPERATION) else $error("skip");
  chk_squash_word:
    assert property (instr_valid && skip_q |=> !file_wr_en && $stable(work_q))
      else $error("squash");
  chk_timer_clear:
    assert property (wf && instr_word[6:0] == TIMER0_ADDR
      |=> prescaler_clear == $past(prescaler_to_timer0)) else $error("timer");
endmodule // file_alu_bit_ops_exec_chk

bind file_alu_bit_ops_exec file_alu_bit_ops_exec_chk
  file_alu_bit_ops_exec_chk_i (.*);

// ===== tb/file_alu_bit_ops_exec_tb.sv
// Self-checking bench for the file-register execute datapath
`timescale 1ns/100ps
module file_alu_bit_ops_exec_tb
  import file_alu_pkg::*;
;
  logic        clk_sys, rstn, instr_valid, file_is_port, prescaler_to_timer0;
  logic        file_wr_en, carry_q, digit_carry_flag_q, zero_q, skip_q;
  logic        prescaler_clear;
  logic [13:0] instr_word, prefetch_word, exec_next_word;
  logic [7:0]  file_rd_data, port_pin_data, file_wr_data, work_q;
  logic [6:0]  file_addr;
  int          n_mismatch = 0, num_checks = 0, cyc = 0;
  wire  [21:0] snap = {prescaler_clear, skip_q, file_wr_en, file_wr_data,
    carry_q, digit_carry_flag_q, zero_q, work_q};
  file_alu_bit_ops_exec file_alu_bit_ops_exec_i (.*);
  task automatic chk(string s, logic [21:0] e, logic [21:0] g);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Write data is only compared while the write strobe is expected
  task automatic ex(logic [13:0] w, logic [7:0] f, logic [21:0] e);
    instr_word <= w;
    file_rd_data <= f;
    instr_valid <= 1'h1;
    @(posedge clk_sys) instr_valid <= 1'h0;
    @(negedge clk_sys);
    chk("outputs", e, e[19] ? snap : {snap[21:19], e[18:11], snap[10:0]});
    @(posedge clk_sys);
  endtask
  task automatic t_alu;
    ex(14'h0720, 8'h17, 22'h000017);
    ex(14'h0720, 8'hC2, 22'h0000D9);
    ex(14'h07A0, 8'h27, 22'h0807D9);
    ex(14'h0520, 8'h0F, 22'h000609);
    file_is_port <= 1'h1;
    ex(14'h05A0, 8'hFF, 22'h080709);
    file_is_port <= 1'h0;
    $display("alu done");
  endtask
  task automatic t_bits;
    for (int i = 0; i < 8; i++)
      ex({4'h4, i[2:0], 7'h20}, 8'hFF,
         {3'h1, ~(8'h01 << i), 11'h709});
    prescaler_to_timer0 <= 1'h1;
    ex(14'h1001, 8'hFF, 22'h2FF709);
    prescaler_to_timer0 <= 1'h0;
    ex(14'h1001, 8'hFF, 22'h0FF709);
    $display("bits done");
  endtask
  task automatic t_skip;
    instr_word <= 14'h18A0;
    file_rd_data <= 8'hFD;
    instr_valid <= 1'h1;
    @(posedge clk_sys) instr_word <= 14'h07A0;
    @(negedge clk_sys);
    chk("skip", 22'h004000, {7'h0, skip_q, exec_next_word});
    @(posedge clk_sys) instr_valid <= 1'h0;
    @(negedge clk_sys);
    chk("squash", 22'h000009, {13'h0, file_wr_en, work_q});
    @(posedge clk_sys);
    prefetch_word <= 14'h1555;
    ex(14'h18A0, 8'h02, 22'h000709);
    @(negedge clk_sys);
    chk("prefetch", 22'h001555, {8'h0, exec_next_word});
    @(posedge clk_sys);
    $display("skip done");
  endtask
  // Mid-run reset, then a request at the first edge after release
  task automatic t_reset;
    rstn <= 1'h0;
    @(posedge clk_sys);
    @(negedge clk_sys);
    chk("reset", 22'h000000, snap);
    chk("reset word", 22'h000000, {8'h0, exec_next_word});
    @(posedge clk_sys) rstn <= 1'h1;
    ex(14'h0720, 8'h3C, 22'h00003C);
    $display("reset done");
  endtask
  initial begin
    clk_sys = 1'h0;
    forever #10 clk_sys = ~clk_sys;
  end
  // About 40 cycles of traffic after 16 of reset; the ceiling leaves ample margin
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 500) begin
      n_mismatch++;
      test_done();
    end
  end
  initial begin
    {rstn, instr_valid, file_is_port, prescaler_to_timer0} = 4'h0;
    {instr_word, file_rd_data} = 22'h000000;
    prefetch_word = 14'h2ABC;
    port_pin_data = 8'hF0;
    repeat (16) @(posedge clk_sys);
    rstn <= 1'h1;
    t_alu();
    t_bits();
    t_skip();
    t_reset();
    test_done();
  end
endmodule // file_alu_bit_ops_exec_tb
